// ===== pmu_serial_write_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_cfg.svh"

module pmu_serial_write_port
	import serial_port_pkg::*;
#(
	parameter int INIT_CYC = `INIT_CYCLES
) (
	// system clock and power-on reset
	input  wire logic     clk_sys,
	input  wire logic     rst,
	// straps and reset pin
	input  wire logic     link_sel,
	input  wire logic     reset_n,
	// serial link clock, already muxed from the pad pair
	input  wire logic     sclk,
	// single-ended link
	input  wire logic     frame_n,
	input  wire logic     serial_data_in,
	// differential link
	input  wire logic     frame_p_lv,
	input  wire logic     frame_n_lv,
	input  wire logic     data_p_lv,
	input  wire logic     data_n_lv,
	// busy open-drain pin
	input  wire logic     busy_n_i,
	output logic          busy_n_o,
	output logic          busy_n_oe,
	// serial data output pin
	output logic          serial_data_out,
	output logic          sdo_oe,
	// committed word and settings
	output serial_word_t  word_q,
	output logic          word_stb_q,
	output logic          gain_ten_q,
	output logic          wake_q
);

	// ************************************************************
	// link selection and link domain
	// ************************************************************

	link_pins_t                pins;
	logic [`WORD_BITS-1:0]     link_shift;
	logic [`CNT_BITS-1:0]      link_count;

	// pad mux: differential receiver resolves p over n
	always_comb begin
		if (!link_sel) begin
			pins.frame_n = frame_n;
			pins.data    = serial_data_in;
		end else begin
			pins.frame_n = frame_p_lv & ~frame_n_lv;
			pins.data    = data_p_lv & ~data_n_lv;
		end
	end

	// falling-edge shifter on the link clock
	link_shifter u_shift (
		.sclk    (sclk),
		.pins    (pins),
		.shift_q (link_shift),
		.count_q (link_count)
	);

	// ************************************************************
	// crossings into clk_sys
	// ************************************************************

	logic frame_s;
	logic reset_s;

	// frame level crosses by two flops
	sync_bit u_frame_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (pins.frame_n),
		.dout    (frame_s)
	);

	// reset pin crosses by two flops
	sync_bit u_reset_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (reset_n),
		.dout    (reset_s)
	);

	// ************************************************************
	// sequencer
	// ************************************************************

	seq_state_t            state_q;
	seq_state_t            state_d;
	logic [`TMR_BITS-1:0]  tmr_q;
	logic [`TMR_BITS-1:0]  tmr_d;
	logic                  frame_q;
	logic                  frame_d;
	logic                  rst_seen_q;
	logic                  rst_seen_d;
	serial_word_t          word_d;
	logic                  word_stb_d;
	logic                  gain_ten_d;
	logic                  wake_d;
	logic                  busy_n_d;
	logic                  frame_rise;
	logic                  frame_fall;
	logic                  word_ok;

	// frame edges on the synchronised level; link data is stable after rise
	always_comb begin
		frame_rise = frame_s & ~frame_q;
		frame_fall = ~frame_s & frame_q;
		word_ok    = (link_count >= `CNT_WORD);
	end

	// next values of the sequencer
	always_comb begin
		state_d    = state_q;
		tmr_d      = tmr_q;
		frame_d    = frame_s;
		rst_seen_d = reset_s;
		word_d     = word_q;
		word_stb_d = 1'h0;
		gain_ten_d = gain_ten_q;
		wake_d     = wake_q;
		busy_n_d   = 1'h1;
		case (state_q)
			ST_INIT: begin
				busy_n_d = 1'h0;
				wake_d   = 1'h0;
				if (!reset_s) begin
					tmr_d = `TMR_ZERO;
				end else if (tmr_q == INIT_CYC[`TMR_BITS-1:0]) begin
					state_d  = ST_IDLE;
					busy_n_d = 1'h1;
				end else begin
					tmr_d = tmr_q + `TMR_ONE;
				end
			end
			ST_IDLE: begin
				if (frame_fall)
					wake_d = 1'h1;
				if (frame_rise && wake_q && word_ok) begin
					wake_d      = 1'h0;
					if (link_shift[`ADDR_MSB:`ADDR_LSB] < `DAC_ADDR_MIN) begin
						word_d.addr = link_shift[`ADDR_MSB:`ADDR_LSB];
						word_d.data = link_shift[`DATA_MSB:0];
						word_stb_d = 1'h1;
						state_d    = ST_BUSY;
						busy_n_d   = 1'h0;
						tmr_d      = `TMR_ZERO;
					end else if (link_shift[`ADDR_MSB:`ADDR_LSB] == `GAIN_ADDR) begin
						word_d.addr = link_shift[`ADDR_MSB:`ADDR_LSB];
						word_d.data = link_shift[`DATA_MSB:0];
						gain_ten_d = link_shift[`GAIN_BIT];
						word_stb_d = 1'h1;
						state_d    = ST_BUSY;
						busy_n_d   = 1'h0;
						tmr_d      = `TMR_ZERO;
					end
				end else if (frame_rise) begin
					wake_d = 1'h0;
				end
			end
			ST_BUSY: begin
				busy_n_d = 1'h0;
				if (tmr_q == `TMR_WRITE) begin
					state_d  = ST_IDLE;
					busy_n_d = 1'h1;
				end else begin
					tmr_d = tmr_q + `TMR_ONE;
				end
			end
			default: begin
				state_d = ST_INIT;
			end
		endcase
		// falling pin reset restarts init from any other state
		if (state_q != ST_INIT && !reset_s && rst_seen_q) begin
			state_d    = ST_INIT;
			tmr_d      = `TMR_ZERO;
			busy_n_d   = 1'h0;
			gain_ten_d = 1'h1;
			word_d     = '0;
			wake_d     = 1'h0;
		end
	end

	// registers; power-on reset enters the same init sequence
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q    <= ST_INIT;
			tmr_q      <= `TMR_ZERO;
			frame_q    <= 1'h1;
			rst_seen_q <= 1'h1;
			word_q     <= '0;
			word_stb_q <= 1'h0;
			gain_ten_q <= 1'h1;
			wake_q     <= 1'h0;
			busy_n_o   <= 1'h0;
		end else begin
			state_q    <= state_d;
			tmr_q      <= tmr_d;
			frame_q    <= frame_d;
			rst_seen_q <= rst_seen_d;
			word_q     <= word_d;
			word_stb_q <= word_stb_d;
			gain_ten_q <= gain_ten_d;
			wake_q     <= wake_d;
			busy_n_o   <= busy_n_d;
		end
	end

	// ************************************************************
	// pin drivers
	// ************************************************************

	logic unused_busy_in;
	logic busy_oe_d;
	logic sdo_d;
	logic sdo_oe_d;

	// busy is open drain: enable only while pulling low; readback not built
	always_comb begin
		busy_oe_d      = ~busy_n_d;
		sdo_d          = 1'h0;
		sdo_oe_d       = 1'h0;
		unused_busy_in = busy_n_i;
	end

	// pin registers; enable tracks busy so the pin is never driven high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_n_oe       <= 1'h1;
			serial_data_out <= 1'h0;
			sdo_oe          <= 1'h0;
		end else begin
			busy_n_oe       <= busy_oe_d;
			serial_data_out <= sdo_d;
			sdo_oe          <= sdo_oe_d;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************

	chk_busy_init: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_INIT |-> !busy_n_o)
		else $error("busy released during init");

	chk_reset_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == ST_INIT && !reset_s) |=> state_q == ST_INIT)
		else $error("init left while reset held");

	chk_no_stb_init: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_INIT |=> !word_stb_q)
		else $error("word taken during reset");

	chk_wake_init: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_INIT |=> !wake_q)
		else $error("interface woke during reset");

	chk_stb_busy: assert property (@(posedge clk_sys) disable iff (rst)
		word_stb_q |-> !busy_n_o ##1 !busy_n_o)
		else $error("busy not low after write");

	chk_busy_end: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(word_stb_q) |-> ##[1:20] busy_n_o)
		else $error("write busy too long");

	chk_commit_rise: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(word_stb_q) |-> $past(frame_rise))
		else $error("commit not on frame rise");

	chk_gain_reset: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q != ST_INIT && !reset_s && rst_seen_q) |=> gain_ten_q)
		else $error("gain not restored by reset");

	chk_sdo_hiz: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_INIT |-> !sdo_oe)
		else $error("output driven in reset");

	chk_busy_od: assert property (@(posedge clk_sys) disable iff (rst)
		busy_n_oe |-> !busy_n_o)
		else $error("busy driven high");

	cov_write: cover property (@(posedge clk_sys) disable iff (rst) word_stb_q);
	cov_gain: cover property (@(posedge clk_sys) disable iff (rst) $fell(gain_ten_q));
	cov_init_done: cover property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_INIT ##1 state_q == ST_IDLE);
	cov_pin_reset: cover property (@(posedge clk_sys) disable iff (rst)
		state_q == ST_IDLE ##1 state_q == ST_INIT);

endmodule
`default_nettype wire

// ===== serial_port_cfg.svh
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// word geometry
`define WORD_BITS        29
`define CNT_BITS         6
`define ADDR_MSB         28
`define ADDR_LSB         22
`define DATA_MSB         21
`define GAIN_ADDR        7'h7f
`define GAIN_BIT         0
`define DAC_ADDR_MIN     7'h40
`define CNT_ZERO         6'h00
`define CNT_ONE          6'h01
`define CNT_SAT          6'h3f
`define CNT_WORD         `CNT_BITS'(`WORD_BITS)

// timing, clk_sys at 40 MHz
`define CLK_HZ           40000000
`define INIT_TIME_US     600
`define INIT_CYCLES      (`INIT_TIME_US * (`CLK_HZ / 1000000))
`define WRITE_TIME_NS    270
`define WRITE_CYCLES     ((`WRITE_TIME_NS * (`CLK_HZ / 1000000)) / 1000)
`define TMR_BITS         16
`define TMR_ZERO         16'h0000
`define TMR_ONE          16'h0001
`define TMR_WRITE        `TMR_BITS'(`WRITE_CYCLES)

`endif

// ===== serial_port_pkg.sv
package serial_port_pkg;

	// one committed serial word
	typedef struct packed {
		logic [6:0]  addr;
		logic [21:0] data;
	} serial_word_t;

	// selected link pins after the pad mux
	typedef struct packed {
		logic frame_n;
		logic data;
	} link_pins_t;

	typedef enum logic [1:0] {
		ST_INIT = 2'b00,
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} seq_state_t;

endpackage

// ===== link_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_cfg.svh"

// link-side shifter: runs on the serial clock, samples on falling edges
module link_shifter
	import serial_port_pkg::*;
(
	// link clock
	input  wire logic               sclk,
	// link pins
	input  wire link_pins_t         pins,
	// captured word, stable between frames
	output logic [`WORD_BITS-1:0]   shift_q,
	output logic [`CNT_BITS-1:0]    count_q
);

	logic [`WORD_BITS-1:0] shift_d;
	logic [`CNT_BITS-1:0]  count_d;
	logic                  frame_q;
	logic                  frame_d;

	// next values: msb first, keep last 29 bits
	always_comb begin
		frame_d = pins.frame_n;
		shift_d = shift_q;
		count_d = count_q;
		if (!pins.frame_n) begin
			shift_d = {shift_q[`WORD_BITS-2:0], pins.data};
			if (frame_q)
				count_d = `CNT_ONE;
			else if (count_q != `CNT_SAT)
				count_d = count_q + `CNT_ONE;
		end
	end

	// falling-edge registers; clock may stop between frames
	always_ff @(negedge sclk) begin
		shift_q <= shift_d;
		count_q <= count_d;
	end

	// frame-start flag: set while frame is high, so a stopped clock still restarts the count
	always_ff @(negedge sclk or posedge pins.frame_n) begin
		if (pins.frame_n)
			frame_q <= 1'h1;
		else
			frame_q <= frame_d;
	end

endmodule
`default_nettype wire

// ===== sync_bit.sv
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser
module sync_bit (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// level
	input  wire logic din,
	output logic      dout
);

	logic meta_q;
	logic meta_d;
	logic out_d;

	// next values
	always_comb begin
		meta_d = din;
		out_d  = meta_q;
	end

	// reset value is idle high
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q <= 1'h1;
			dout   <= 1'h1;
		end else begin
			meta_q <= meta_d;
			dout   <= out_d;
		end
	end

endmodule
`default_nettype wire

// ===== host_link.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the link: burst clock, frame and msb-first data on both link types
module host_link (
	// link clock, parked high outside frames except during idle_clocks
	output logic sclk,
	// single-ended link
	output logic frame_n,
	output logic serial_data_in,
	// differential link
	output logic frame_p_lv,
	output logic frame_n_lv,
	output logic data_p_lv,
	output logic data_n_lv
);
	logic fr;
	logic dat;

	// both link types carry the same levels, pairs complementary
	always_comb begin
		frame_n = fr;
		serial_data_in = dat;
		frame_p_lv = fr;
		frame_n_lv = ~fr;
		data_p_lv = dat;
		data_n_lv = ~dat;
	end

	// idle: frame high, clock parked high
	initial begin
		sclk = 1'b1;
		fr = 1'b1;
		dat = 1'b0;
	end

	// one frame, one bit per falling clock edge, 30 ns clock period
	task automatic send(input logic [31:0] w, input int nbits);
		fr = 1'b0;
		#20;
		for (int i = nbits - 1; i >= 0; i--) begin
			dat = w[i];
			#15 sclk = 1'b0;
			#15 sclk = 1'b1;
		end
		#20 fr = 1'b1;
		dat = ~dat;
		#20;
	endtask

	// free-running clock outside a frame: edges with frame high shift nothing
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			#15 sclk = 1'b0;
			#15 sclk = 1'b1;
		end
	endtask
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	import serial_port_pkg::*;
	typedef struct {
		logic        sel;
		int          nbits;
		logic [31:0] w;
		logic        commit;
		logic        gain;
	} row_t;
	logic         clk_sys;
	logic         rst;
	logic         link_sel;
	logic         reset_n;
	wire logic    sclk;
	wire logic    frame_n;
	wire logic    serial_data_in;
	wire logic    frame_p_lv;
	wire logic    frame_n_lv;
	wire logic    data_p_lv;
	wire logic    data_n_lv;
	wire logic    busy_n_i;
	logic         busy_n_o;
	logic         busy_n_oe;
	logic         serial_data_out;
	logic         sdo_oe;
	serial_word_t word_q;
	logic         word_stb_q;
	logic         gain_ten_q;
	logic         wake_q;
	logic [28:0]  last_w;
	int           num_errors;
	int           n_tests;
	int           cnt;
	bit           hit;
	row_t rows[9] = '{
		'{1'b0, 29, {3'h0, 7'h01, 22'h2a5a5a}, 1'b1, 1'b1},
		'{1'b1, 29, {3'h0, 7'h3f, 22'h15a5a5}, 1'b1, 1'b1},
		'{1'b0, 32, {3'h5, 7'h12, 22'h0abcde}, 1'b1, 1'b1},
		'{1'b0, 28, {3'h0, 7'h02, 22'h000001}, 1'b0, 1'b1},
		'{1'b0, 29, {3'h0, 7'h40, 22'h000000}, 1'b0, 1'b1},
		'{1'b1, 29, {3'h0, 7'h7e, 22'h3ffffe}, 1'b0, 1'b1},
		'{1'b1, 29, {3'h0, 7'h7f, 22'h000000}, 1'b1, 1'b0},
		'{1'b0, 29, {3'h0, 7'h7f, 22'h000001}, 1'b1, 1'b1},
		'{1'b1, 29, {3'h0, 7'h7f, 22'h000000}, 1'b1, 1'b0}};

	// busy pin has a pull-up
	assign busy_n_i = busy_n_oe ? busy_n_o : 1'b1;

	// 40 MHz system clock
	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	pmu_serial_write_port #(.INIT_CYC(50)) dut (.clk_sys(clk_sys), .rst(rst),
		.link_sel(link_sel), .reset_n(reset_n), .sclk(sclk), .frame_n(frame_n),
		.serial_data_in(serial_data_in), .frame_p_lv(frame_p_lv), .frame_n_lv(frame_n_lv),
		.data_p_lv(data_p_lv), .data_n_lv(data_n_lv), .busy_n_i(busy_n_i),
		.busy_n_o(busy_n_o), .busy_n_oe(busy_n_oe), .serial_data_out(serial_data_out),
		.sdo_oe(sdo_oe), .word_q(word_q), .word_stb_q(word_stb_q),
		.gain_ten_q(gain_ten_q), .wake_q(wake_q));

	host_link host (.sclk(sclk), .frame_n(frame_n), .serial_data_in(serial_data_in),
		.frame_p_lv(frame_p_lv), .frame_n_lv(frame_n_lv), .data_p_lv(data_p_lv),
		.data_n_lv(data_n_lv));

	// counts and verdict
	task end_sim;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// look for a commit strobe within a window
	task wait_stb(input int lim, output bit h);
		h = 0;
		for (int i = 0; i < lim; i++) begin
			@(negedge clk_sys);
			if (word_stb_q === 1'b1)
				h = 1;
		end
	endtask

	// cycles until busy released, strobes seen meanwhile
	task time_init(output int c, output bit h);
		h = 0;
		for (c = 0; c < 300 && busy_n_o !== 1'b1; c++) begin
			@(negedge clk_sys);
			if (word_stb_q === 1'b1)
				h = 1;
		end
		if (busy_n_o !== 1'b1) begin
			num_errors++;
			$display("[FAIL] busy release timed out");
			end_sim;
		end
	endtask

	initial begin
		rst = 1'b1;
		link_sel = 1'b0;
		reset_n = 1'b1;
		repeat (16) @(negedge clk_sys);
		check("busy in reset", 0, busy_n_o);
		check("sdo enable", 0, sdo_oe);
		check("sdo data", 0, serial_data_out);
		check("busy enable", 1, busy_n_oe);
		rst = 1'b0;
		// frame during init is ignored
		fork
			host.send({3'h0, 7'h7f, 22'h0}, 29);
			time_init(cnt, hit);
		join
		check("init span", 1, cnt >= 50 && cnt <= 56);
		check("init frame", 0, hit);
		check("gain default", 1, gain_ten_q);
		// ordinary writes
		foreach (rows[i]) begin
			@(negedge clk_sys);
			link_sel = rows[i].sel;
			if (i % 2 == 1)
				host.idle_clocks(3);
			host.send(rows[i].w, rows[i].nbits);
			wait_stb(8, hit);
			check("commit", rows[i].commit, hit);
			if (hit)
				check("word", rows[i].w[28:0], word_q);
			if (rows[i].commit)
				last_w = rows[i].w[28:0];
			check("word held", last_w, word_q);
			check("gain", rows[i].gain, gain_ten_q);
			time_init(cnt, hit);
			if (rows[i].commit)
				check("write busy", 1, cnt >= 4 && cnt <= 8);
		end
		// pin reset restores gain, holds busy, ignores the link
		reset_n = 1'b0;
		host.send({3'h0, 7'h7f, 22'h0}, 29);
		repeat (40) @(negedge clk_sys);
		check("pin busy", 0, busy_n_o);
		check("pin gain", 1, gain_ten_q);
		check("pin sdo", 0, sdo_oe);
		reset_n = 1'b1;
		time_init(cnt, hit);
		check("pin init", 1, cnt >= 50 && cnt <= 56);
		// normal operation resumes, interface wakes in frame
		fork
			host.send({3'h0, 7'h7f, 22'h0}, 29);
			begin
				repeat (20) @(negedge clk_sys);
				check("wake", 1, wake_q);
			end
		join
		wait_stb(8, hit);
		check("resume", 1, hit);
		check("resume gain", 0, gain_ten_q);
		end_sim;
	end
endmodule

`default_nettype wire
